// ==== hdl/oma_array_top.v ====
// output macrocell array: eight macrocells behind a 64-term and-array,
// configured and preloaded over an avalon-mm slave with waitrequest
// assumes all pins come from outside the clock domain and are synchronised
// here; the pin clock must be slow against the system clock (3+ cycles/level)
// outputs trail the pins by three system clocks; registered outputs trail the clock pin by four
// the system reset stands in for power-on clear
//
// Operation
// - sync mode bit and global config bit pick one mode for all macrocells
// - each macrocell has a polarity bit inverting its output in every mode
// - an io config bit per macrocell; sixteen per-cell bits plus two globals
// - registered mode: all registers share one clock and one output enable
// - registered mode: clock pin and enable pin are never array inputs
// - registered mode: each macrocell chosen as register or input/output
// - register sums eight terms; input/output sums seven, eighth is enable
// - input/output cell usable as pure input or pure output
// - complex mode: clock/enable pins enter via outer cells' feedback paths
// - simple mode: feedback comes from the neighbouring macrocell's pin, except the outer cells carry clock/enable
// - simple mode: two inner cells are always outputs, never feedback
// - hold 64 user signature fuses in eight bytes, plus per-term disables
// - registers clear at power-on and accept a preload value
// - complex mode: seven terms to output, one term drives output enable
// - simple mode: outputs always enabled, eight terms, programmable polarity
`include "oma_defs.vh"

module oma_array_top #(
  parameter NUM_CELLS = 8,
  parameter NUM_INPUTS = 8
) (
  input  wire                  i_sys_clk,
  input  wire                  i_sys_rst,
  // avalon-mm slave
  input  wire [8:0]            i_avs_address,
  input  wire                  i_avs_read,
  input  wire                  i_avs_write,
  input  wire [31:0]           i_avs_writedata,
  output wire [31:0]           o_avs_readdata,
  output wire                  o_avs_waitrequest,
  // device pins
  input  wire                  i_pin_clk,
  input  wire                  i_pin_oe_n,
  input  wire [NUM_INPUTS-1:0] i_pin_in,
  input  wire [NUM_CELLS-1:0]  i_mc_pin,
  output wire [NUM_CELLS-1:0]  o_mc_pin,
  output wire [NUM_CELLS-1:0]  o_mc_pin_oe
);

  localparam NUM_TERMS = NUM_CELLS * 8;
  localparam NUM_SIGS  = NUM_CELLS + NUM_INPUTS;
  localparam NUM_LITS  = 2 * NUM_SIGS;
  localparam SYNC_W    = NUM_CELLS + NUM_INPUTS + 2;
  // idle pin levels: clock low, enable high (outputs off)
  localparam [SYNC_W-1:0] SYNC_RST = {1'b0, 1'b1, {(SYNC_W-2){1'b0}}};

  // --------------------------------------------------------------------------
  // configuration state
  // --------------------------------------------------------------------------
  reg  [1:0]           ctrl_q;
  reg  [NUM_CELLS-1:0] polarity_q;
  reg  [NUM_CELLS-1:0] io_config_q;
  reg  [63:0]          ptd_q;
  reg  [63:0]          sig_q;
  reg  [NUM_LITS-1:0]  term_fuse_q [0:NUM_TERMS-1];
  reg                  preload_stb_q;
  reg  [NUM_CELLS-1:0] preload_val_q;

  // --------------------------------------------------------------------------
  // bus state
  // --------------------------------------------------------------------------
  reg                  ack_q;
  reg  [31:0]          rdata_q;
  reg  [31:0]          rdata_d;
  wire                 req;
  wire                 wr_go;
  wire                 rd_go;
  wire                 term_sel;
  wire [5:0]           term_idx;

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  reg  [SYNC_W-1:0]    sync1_q;
  reg  [SYNC_W-1:0]    sync2_q;
  reg                  clk_last_q;
  wire                 clk_s;
  wire                 oe_n_s;
  wire [NUM_INPUTS-1:0] in_s;
  wire [NUM_CELLS-1:0] pin_s;
  wire                 reg_edge;

  // --------------------------------------------------------------------------
  // array signals
  // --------------------------------------------------------------------------
  reg  [1:0]           mode;
  reg  [NUM_CELLS-1:0] col;
  wire [NUM_SIGS-1:0]  sigs;
  wire [NUM_LITS-1:0]  lits;
  wire [NUM_TERMS-1:0] terms;
  wire [NUM_CELLS-1:0] reg_q;
  wire [NUM_CELLS-1:0] cell_oe;
  integer              k;
  integer              j;

  // --------------------------------------------------------------------------
  // mode decode
  // --------------------------------------------------------------------------
  // sync clear means registered mode
  always @* begin
    if (!ctrl_q[`OMA_CTRL_SYNC_BIT]) begin
      mode = `OMA_MODE_REG;
    end else if (ctrl_q[`OMA_CTRL_GCFG_BIT]) begin
      mode = `OMA_MODE_CPX;
    end else begin
      mode = `OMA_MODE_SIMPLE;
    end
  end

  // --------------------------------------------------------------------------
  // synchronisers: only the second stage is read
  // --------------------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      sync1_q    <= SYNC_RST;
      sync2_q    <= SYNC_RST;
      clk_last_q <= 1'b0;
    end else begin
      sync1_q    <= {i_pin_clk, i_pin_oe_n, i_pin_in, i_mc_pin};
      sync2_q    <= sync1_q;
      clk_last_q <= clk_s;
    end
  end

  // pin levels shorter than one clock may be missed
  assign pin_s    = sync2_q[NUM_CELLS-1:0];
  assign in_s     = sync2_q[NUM_CELLS+NUM_INPUTS-1:NUM_CELLS];
  assign oe_n_s   = sync2_q[SYNC_W-2];
  assign clk_s    = sync2_q[SYNC_W-1];
  // one shared clock edge for every registered cell
  assign reg_edge = clk_s & ~clk_last_q;

  // --------------------------------------------------------------------------
  // feedback column routing into the and-array
  // --------------------------------------------------------------------------
  always @* begin
    col = {NUM_CELLS{1'b0}};
    case (mode)
      `OMA_MODE_REG: begin
        // clock and enable pins never reach the array here
        // io cells feed back their own pin
        for (k = 0; k < NUM_CELLS; k = k + 1) begin
          col[k] = io_config_q[k] ? pin_s[k] : reg_q[k];
        end
      end
      `OMA_MODE_CPX: begin
        for (k = 1; k < NUM_CELLS - 1; k = k + 1) begin
          col[k] = pin_s[k];
        end
        // enable pin enters true-high
        col[NUM_CELLS-1] = clk_s;
        col[0]           = ~oe_n_s;
      end
      `OMA_MODE_SIMPLE: begin
        // outer half shifts outward so the two inner pins are never read
        for (k = 1; k < NUM_CELLS / 2; k = k + 1) begin
          col[k] = pin_s[k-1];
        end
        for (k = NUM_CELLS / 2; k < NUM_CELLS - 1; k = k + 1) begin
          col[k] = pin_s[k+1];
        end
        col[NUM_CELLS-1] = clk_s;
        col[0]           = ~oe_n_s;
      end
      default: begin
        col = {NUM_CELLS{1'b0}};
      end
    endcase
  end

  assign sigs = {col, in_s};
  assign lits = {~sigs, sigs};

  // --------------------------------------------------------------------------
  // product terms: a set fuse connects its literal; an erased term
  // (all fuses set) holds a signal and its complement and so stays low
  // --------------------------------------------------------------------------
  // a disabled term is forced low whatever its fuses
  genvar t;
  generate
    for (t = 0; t < NUM_TERMS; t = t + 1) begin : g_term
      assign terms[t] = ~ptd_q[t] & (&(~term_fuse_q[t] | lits));
    end
  endgenerate

  // --------------------------------------------------------------------------
  // macrocells
  // --------------------------------------------------------------------------
  // cells share mode, edge and synchronised enable
  genvar c;
  generate
    for (c = 0; c < NUM_CELLS; c = c + 1) begin : g_cell
      oma_macrocell u_cell (
        .i_sys_clk      (i_sys_clk),
        .i_sys_rst      (i_sys_rst),
        .i_mode         (mode),
        .i_polarity     (polarity_q[c]),
        .i_io_config    (io_config_q[c]),
        .i_force_output ((c == NUM_CELLS/2 - 1) || (c == NUM_CELLS/2)),
        .i_terms        (terms[c*8 +: 8]),
        .i_reg_edge     (reg_edge),
        .i_oe_n         (oe_n_s),
        .i_preload_stb  (preload_stb_q),
        .i_preload_val  (preload_val_q[c]),
        .o_pin          (o_mc_pin[c]),
        .o_pin_oe       (cell_oe[c]),
        .o_reg_q        (reg_q[c])
      );
    end
  endgenerate

  assign o_mc_pin_oe = cell_oe;

  // --------------------------------------------------------------------------
  // avalon-mm slave: one wait cycle, then the request completes
  // read data is caught in the wait cycle;
  // a write lands only at the completion edge
  // --------------------------------------------------------------------------
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_q;
  assign wr_go             = i_avs_write & ack_q;
  assign rd_go             = i_avs_read & ~ack_q;
  assign term_sel          = i_avs_address[8];
  assign term_idx          = i_avs_address[7:2];
  assign o_avs_readdata    = rdata_q;

  // exactly one wait cycle per request
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // --------------------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctrl_q        <= `OMA_CTRL_RST;
      polarity_q    <= {NUM_CELLS{1'b0}};
      io_config_q   <= {NUM_CELLS{1'b0}};
      ptd_q         <= 64'h0000000000000000;
      sig_q         <= 64'h0000000000000000;
      preload_stb_q <= 1'b0;
      preload_val_q <= {NUM_CELLS{1'b0}};
      // erase every term: no cell driven yet
      for (j = 0; j < NUM_TERMS; j = j + 1) begin
        term_fuse_q[j] <= `OMA_TERM_RST;
      end
    end else begin
      preload_stb_q <= 1'b0;
      // bit 8 picks the term words
      if (wr_go && term_sel) begin
        term_fuse_q[term_idx] <= i_avs_writedata[NUM_LITS-1:0];
      end else if (wr_go) begin
        case (i_avs_address)
          `OMA_ADDR_CTRL: begin
            ctrl_q <= i_avs_writedata[1:0];
          end
          // no mode check: polarity acts in every mode
          `OMA_ADDR_POLARITY: begin
            polarity_q <= i_avs_writedata[NUM_CELLS-1:0];
          end
          `OMA_ADDR_IO_CFG: begin
            io_config_q <= i_avs_writedata[NUM_CELLS-1:0];
          end
          `OMA_ADDR_PTD_LO: begin
            ptd_q[31:0] <= i_avs_writedata;
          end
          `OMA_ADDR_PTD_HI: begin
            ptd_q[63:32] <= i_avs_writedata;
          end
          `OMA_ADDR_SIG_LO: begin
            sig_q[31:0] <= i_avs_writedata;
          end
          `OMA_ADDR_SIG_HI: begin
            sig_q[63:32] <= i_avs_writedata;
          end
          `OMA_ADDR_PRELOAD: begin
            // wins over a pin clock edge in the same cycle
            preload_stb_q <= 1'b1;
            preload_val_q <= i_avs_writedata[NUM_CELLS-1:0];
          end
          default: begin
            preload_stb_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // register reads; unmapped addresses read zero
  // --------------------------------------------------------------------------
  always @* begin
    rdata_d = 32'h00000000;
    if (term_sel) begin
      rdata_d[NUM_LITS-1:0] = term_fuse_q[term_idx];
    end else begin
      case (i_avs_address)
        `OMA_ADDR_CTRL:     rdata_d[1:0] = ctrl_q;
        `OMA_ADDR_POLARITY: rdata_d[NUM_CELLS-1:0] = polarity_q;
        `OMA_ADDR_IO_CFG:   rdata_d[NUM_CELLS-1:0] = io_config_q;
        `OMA_ADDR_PTD_LO:   rdata_d = ptd_q[31:0];
        `OMA_ADDR_PTD_HI:   rdata_d = ptd_q[63:32];
        `OMA_ADDR_SIG_LO:   rdata_d = sig_q[31:0];
        `OMA_ADDR_SIG_HI:   rdata_d = sig_q[63:32];
        `OMA_ADDR_PRELOAD:  rdata_d[NUM_CELLS-1:0] = reg_q;
        // registered enables, as seen on the pins
        `OMA_ADDR_STATUS: begin
          rdata_d[NUM_CELLS-1:0] = reg_q;
          rdata_d[`OMA_STAT_OE_LSB +: NUM_CELLS] = cell_oe;
          rdata_d[`OMA_STAT_MODE_LSB +: 2] = mode;
        end
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // held between reads
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rdata_q <= 32'h00000000;
    end else if (rd_go) begin
      rdata_q <= rdata_d;
    end
  end

endmodule // oma_array_top

// ==== hdl/oma_defs.vh ====
// constants for the output macrocell array: register map, field positions,
// reset values and mode codes; included by every design file of the block
`ifndef OMA_DEFS_VH
`define OMA_DEFS_VH

// ----------------------------------------------------------------------------
// register byte addresses (one 32-bit word each)
// ----------------------------------------------------------------------------
`define OMA_ADDR_CTRL      9'h000
`define OMA_ADDR_POLARITY  9'h004
`define OMA_ADDR_IO_CFG    9'h008
`define OMA_ADDR_PTD_LO    9'h00c
`define OMA_ADDR_PTD_HI    9'h010
`define OMA_ADDR_SIG_LO    9'h014
`define OMA_ADDR_SIG_HI    9'h018
`define OMA_ADDR_PRELOAD   9'h01c
`define OMA_ADDR_STATUS    9'h020
`define OMA_ADDR_TERM_BASE 9'h100

// ----------------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------------
`define OMA_CTRL_SYNC_BIT  0
`define OMA_CTRL_GCFG_BIT  1
`define OMA_STAT_OE_LSB    8
`define OMA_STAT_MODE_LSB  16

// ----------------------------------------------------------------------------
// modes, decoded from {sync_mode_bit, global_config_bit}
// ----------------------------------------------------------------------------
`define OMA_MODE_REG       2'h0
`define OMA_MODE_CPX       2'h1
`define OMA_MODE_SIMPLE    2'h2

// ----------------------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------------------
`define OMA_CTRL_RST       2'h0
`define OMA_TERM_RST       32'hffffffff
`define OMA_NUM_CFG_BITS   16
`define OMA_SIG_FUSE_FIRST 2056
`define OMA_SIG_FUSE_LAST  2119
`define OMA_SIG_BITS       64

`endif

// ==== hdl/oma_macrocell.v ====
// one output macrocell: output logic, polarity, output enable and register
// assumes product terms arrive already gated by their disable fuses
`include "oma_defs.vh"

module oma_macrocell (
  input  wire       i_sys_clk,
  input  wire       i_sys_rst,
  input  wire [1:0] i_mode,
  input  wire       i_polarity,
  input  wire       i_io_config,
  input  wire       i_force_output,
  input  wire [7:0] i_terms,
  input  wire       i_reg_edge,
  input  wire       i_oe_n,
  input  wire       i_preload_stb,
  input  wire       i_preload_val,
  output wire       o_pin,
  output wire       o_pin_oe,
  output wire       o_reg_q
);

  reg  reg_q;
  reg  pin_q;
  reg  pin_oe_q;
  reg  pin_d;
  reg  pin_oe_d;
  wire sum8;
  wire sum7;

  assign sum8 = |i_terms;
  assign sum7 = |i_terms[7:1];

  // --------------------------------------------------------------------------
  // output selection per mode
  // --------------------------------------------------------------------------
  always @* begin
    pin_d    = 1'b0;
    pin_oe_d = 1'b0;
    case (i_mode)
      `OMA_MODE_REG: begin
        if (!i_io_config) begin
          pin_d    = reg_q;
          pin_oe_d = ~i_oe_n;
        end else begin
          pin_d    = sum7 ^ i_polarity;
          pin_oe_d = i_terms[0];
        end
      end
      `OMA_MODE_CPX: begin
        pin_d    = sum7 ^ i_polarity;
        pin_oe_d = i_terms[0];
      end
      `OMA_MODE_SIMPLE: begin
        pin_d    = sum8 ^ i_polarity;
        pin_oe_d = i_force_output | ~i_io_config;
      end
      default: begin
        pin_d    = 1'b0;
        pin_oe_d = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // register and pin flops
  // --------------------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      reg_q    <= 1'b0;
      pin_q    <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      if (i_preload_stb) begin
        reg_q <= i_preload_val;
      end else if (i_mode == `OMA_MODE_REG && !i_io_config && i_reg_edge) begin
        reg_q <= sum8 ^ i_polarity;
      end
      pin_q    <= pin_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign o_pin    = pin_q;
  assign o_pin_oe = pin_oe_q;
  assign o_reg_q  = reg_q;

endmodule // oma_macrocell

// ==== sim/oma_array_top_properties.sv ====
// checker for the output macrocell array: bus wait states and pin enables
// bound to oma_array_top; mode and io settings are shadowed from bus writes
`include "oma_defs.vh"
module oma_array_top_properties #(
  parameter NUM_CELLS  = 8,
  parameter NUM_INPUTS = 8
) (
  input wire                  i_sys_clk,
  input wire                  i_sys_rst,
  input wire [8:0]            i_avs_address,
  input wire                  i_avs_read,
  input wire                  i_avs_write,
  input wire [31:0]           i_avs_writedata,
  input wire [31:0]           o_avs_readdata,
  input wire                  o_avs_waitrequest,
  input wire                  i_pin_clk,
  input wire                  i_pin_oe_n,
  input wire [NUM_INPUTS-1:0] i_pin_in,
  input wire [NUM_CELLS-1:0]  i_mc_pin,
  input wire [NUM_CELLS-1:0]  o_mc_pin,
  input wire [NUM_CELLS-1:0]  o_mc_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------------
  // shadow of mode and io settings
  // ---------------------------------------------------------------------
  reg  [1:0] ctrl_q;
  reg  [7:0] io_q;
  wire       req      = i_avs_read | i_avs_write;
  wire       wr_done  = i_avs_write & ~o_avs_waitrequest;
  wire [8:0] word     = i_avs_address & 9'h1fc;
  wire       reg_mode = ~ctrl_q[`OMA_CTRL_SYNC_BIT];
  wire       simple   = ctrl_q == 2'h1;
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctrl_q <= `OMA_CTRL_RST;
      io_q   <= 8'h00;
    end else if (wr_done && word == `OMA_ADDR_CTRL) begin
      ctrl_q <= i_avs_writedata[1:0];
    end else if (wr_done && word == `OMA_ADDR_IO_CFG) begin
      io_q   <= i_avs_writedata[7:0];
    end
  end
  // ---------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------
  default clocking dflt @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  wait_first_a: assert property (req && !$past(req) |-> o_avs_waitrequest)
    else $error("first request cycle not stalled");
  wait_once_a: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("more than one wait cycle");
  ctrl_read_a: assert property (i_avs_read && !o_avs_waitrequest && word == `OMA_ADDR_CTRL
    |-> o_avs_readdata == {30'h0, ctrl_q}) else $error("mode bits read back wrong");
  reset_clear_a: assert property ($fell(i_sys_rst) |-> o_mc_pin == '0 && o_mc_pin_oe == '0)
    else $error("outputs not cleared by reset");
  oe_float_a: assert property ((reg_mode && io_q == 8'h00 && i_pin_oe_n)[*5]
    |-> o_mc_pin_oe == '0) else $error("registered output driven while enable high");
  oe_shared_a: assert property ((reg_mode && io_q == 8'h00 && !i_pin_oe_n)[*5]
    |-> o_mc_pin_oe == '1) else $error("registered output floats while enable low");
  inner_out_a: assert property (simple[*3] |-> o_mc_pin_oe[4:3] == 2'b11)
    else $error("inner cell not driving in simple mode");
  simple_in_a: assert property ((simple && io_q == 8'hff)[*3] |-> o_mc_pin_oe == 8'h18)
    else $error("simple input cell drives its pin");
  simple_out_a: assert property ((simple && io_q == 8'h00)[*3] |-> o_mc_pin_oe == 8'hff)
    else $error("simple output not always enabled");
  cover property (wr_done);
  cover property (i_avs_read && !o_avs_waitrequest);
  cover property (reg_mode && $rose(i_pin_clk));
  cover property (simple && o_mc_pin_oe == 8'h18);
endmodule // oma_array_top_properties

bind oma_array_top oma_array_top_properties #(
  .NUM_CELLS(NUM_CELLS), .NUM_INPUTS(NUM_INPUTS)
) u_oma_array_top_properties (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_pin_clk(i_pin_clk), .i_pin_oe_n(i_pin_oe_n), .i_pin_in(i_pin_in),
  .i_mc_pin(i_mc_pin), .o_mc_pin(o_mc_pin), .o_mc_pin_oe(o_mc_pin_oe)
);

// ==== sim/oma_board.sv ====
// board glue around the macrocell array: clock, enable and input pins
// assumes the pin clock stays slow against the system clock
module oma_board (
  input  wire        i_sys_clk,
  input  wire  [7:0] i_dut_pin,
  input  wire  [7:0] i_dut_oe,
  output logic       o_pin_clk,
  output logic       o_pin_oe_n,
  output logic [7:0] o_pin_in,
  output wire  [7:0] o_mc_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] drv_en;
  logic [7:0] drv_val;
  logic [7:0] float_q;
  initial begin
    o_pin_clk  = 1'b0;
    o_pin_oe_n = 1'b1;
    o_pin_in   = 8'h00;
    drv_en     = 8'h00;
    drv_val    = 8'h00;
    float_q    = 8'h55;
  end
  // undriven lines toggle so a floating pin never reads as a steady level
  always @(posedge i_sys_clk) float_q <= ~float_q;
  assign o_mc_pin = (i_dut_oe & i_dut_pin) | (~i_dut_oe & drv_en & drv_val) |
                    (~i_dut_oe & ~drv_en & float_q);
  // each level is held long enough to pass the two-flop synchronisers
  task set_pins(input logic ck, input logic oe_n, input logic [7:0] din);
    @(posedge i_sys_clk);
    o_pin_clk  <= ck;
    o_pin_oe_n <= oe_n;
    o_pin_in   <= din;
    repeat (7) @(posedge i_sys_clk);
  endtask
  task pulse_clk;
    @(posedge i_sys_clk);
    o_pin_clk <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    o_pin_clk <= 1'b0;
    repeat (7) @(posedge i_sys_clk);
  endtask
  task drive_cell(input logic [7:0] en, input logic [7:0] val);
    @(posedge i_sys_clk);
    drv_en  <= en;
    drv_val <= val;
    repeat (7) @(posedge i_sys_clk);
  endtask
endmodule // oma_board

// ==== sim/oma_array_top_bench.sv ====
// self-checking bench for the output macrocell array
// assumes oma_defs.vh on the include path; board model in oma_board
`include "oma_defs.vh"
module oma_array_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, sys_rst, rd_en, wr_en, waitreq, pin_clk, pin_oe_n;
  logic [8:0]  addr;
  logic [31:0] wdata, rdata, rd;
  logic [7:0]  pin_in, mc_pin, pin_out, pin_oe;
  int          failures, num_checks;
  logic [1:0]  mode_tab [4] = '{`OMA_MODE_REG, `OMA_MODE_SIMPLE, `OMA_MODE_REG, `OMA_MODE_CPX};
  logic [8:0]  rw_a [5] = '{`OMA_ADDR_POLARITY, `OMA_ADDR_IO_CFG, `OMA_ADDR_SIG_LO,
                            `OMA_ADDR_SIG_HI, `OMA_ADDR_PTD_HI};
  logic [31:0] rw_e [5] = '{32'hef, 32'hef, 32'h89abcdef, 32'h89abcdef, 32'h89abcdef};

  oma_array_top u_oma_array_top (
    .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_avs_address(addr), .i_avs_read(rd_en),
    .i_avs_write(wr_en), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_pin_clk(pin_clk), .i_pin_oe_n(pin_oe_n),
    .i_pin_in(pin_in), .i_mc_pin(mc_pin), .o_mc_pin(pin_out), .o_mc_pin_oe(pin_oe));
  oma_board u_oma_board (
    .i_sys_clk(sys_clk), .i_dut_pin(pin_out), .i_dut_oe(pin_oe), .o_pin_clk(pin_clk),
    .o_pin_oe_n(pin_oe_n), .o_pin_in(pin_in), .o_mc_pin(mc_pin));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ---------------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------------
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task check_pins(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until waitrequest is sampled low; only the watchdog ends a wait
  task bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr_en <= w;
    rd_en <= ~w;
    addr  <= a;
    wdata <= d;
    do begin
      @(posedge sys_clk);
    end while (waitreq !== 1'b0);
    rd = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask
  task wr(input logic [8:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rchk(input logic [8:0] a, input logic [31:0] mask, input logic [31:0] exp,
            input string what);
    bus(1'b0, a, 32'h0);
    check(what, exp, rd & mask);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    complete_run;
  end
  // ---------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    rd_en = 1'b0;
    wr_en = 1'b0;
    addr = 9'h000;
    wdata = 32'h0;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rchk(`OMA_ADDR_STATUS, '1, 32'h0, "status");
    rchk(`OMA_ADDR_TERM_BASE, '1, `OMA_TERM_RST, "term");
    rchk(9'h024, '1, 32'h0, "unmapped");
    check_pins("oe", 8'h00, pin_oe);
    $display("test reset done");
    wr(`OMA_ADDR_CTRL, '1);
    rchk(`OMA_ADDR_CTRL, '1, 32'h3, "ctrl");
    for (int m = 0; m < 4; m++) begin
      wr(`OMA_ADDR_CTRL, m);
      rchk(`OMA_ADDR_STATUS, 32'h30000, {14'h0, mode_tab[m], 16'h0}, "mode");
    end
    for (int i = 0; i < 5; i++) begin
      wr(rw_a[i], 32'h89abcdef);
      rchk(rw_a[i], '1, rw_e[i], "rw");
      wr(rw_a[i], 32'h0);
    end
    $display("test registers done");
    wr(`OMA_ADDR_CTRL, 32'h0);
    wr(9'h120, 32'h1);
    u_oma_board.set_pins(1'b0, 1'b1, 8'h01);
    u_oma_board.pulse_clk;
    rchk(`OMA_ADDR_STATUS, 32'hff, 32'h02, "capture");
    wr(`OMA_ADDR_POLARITY, 32'h04);
    u_oma_board.pulse_clk;
    rchk(`OMA_ADDR_STATUS, 32'hff, 32'h06, "polarity");
    wr(`OMA_ADDR_PTD_LO, 32'h100);
    u_oma_board.pulse_clk;
    rchk(`OMA_ADDR_STATUS, 32'hff, 32'h04, "disabled term");
    u_oma_board.set_pins(1'b0, 1'b0, 8'h01);
    check_pins("shared oe", 8'hff, pin_oe);
    check_pins("reg out", 8'h04, pin_out);
    wr(`OMA_ADDR_PRELOAD, 32'ha5);
    rchk(`OMA_ADDR_STATUS, 32'hff, 32'ha5, "preload");
    check_pins("preload out", 8'ha5, pin_out);
    u_oma_board.set_pins(1'b0, 1'b1, 8'h01);
    check_pins("oe high", 8'h00, pin_oe);
    $display("test registered done");
    wr(`OMA_ADDR_PTD_LO, 32'h0);
    wr(`OMA_ADDR_POLARITY, 32'h0);
    wr(`OMA_ADDR_IO_CFG, 32'h02);
    wr(9'h124, 32'h2);
    u_oma_board.set_pins(1'b0, 1'b1, 8'h03);
    check_pins("io oe", 8'h02, pin_oe);
    check_pins("io out", 8'h02, pin_out & 8'h02);
    u_oma_board.set_pins(1'b0, 1'b1, 8'h02);
    check_pins("io off", 8'h00, pin_oe);
    $display("test io done");
    wr(`OMA_ADDR_CTRL, 32'h3);
    wr(9'h140, 32'h8000);
    wr(9'h144, 32'h100);
    u_oma_board.set_pins(1'b1, 1'b0, 8'h02);
    check_pins("cpx oe", 8'h04, pin_oe);
    check_pins("cpx out", 8'h04, pin_out & 8'h04);
    u_oma_board.set_pins(1'b0, 1'b1, 8'h02);
    check_pins("cpx off", 8'h00, pin_oe);
    $display("test complex done");
    wr(`OMA_ADDR_CTRL, 32'h1);
    wr(`OMA_ADDR_IO_CFG, 32'hff);
    wr(9'h160, 32'h200);
    u_oma_board.drive_cell(8'h01, 8'h01);
    check_pins("inner oe", 8'h18, pin_oe);
    check_pins("neighbour", 8'h08, pin_out & 8'h18);
    u_oma_board.drive_cell(8'h01, 8'h00);
    check_pins("neighbour", 8'h00, pin_out & 8'h18);
    u_oma_board.drive_cell(8'h00, 8'h00);
    wr(`OMA_ADDR_IO_CFG, 32'h0);
    u_oma_board.set_pins(1'b0, 1'b1, 8'h02);
    check_pins("simple oe", 8'hff, pin_oe);
    $display("test simple done");
    complete_run;
  end
endmodule // oma_array_top_bench
